// ==== hw/wdsc_top.sv ====
`timescale 1ns/1ps
module wdsc_top
  import wdsc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic POWER_SAVE_ENABLE_PIN_N,
  input wire logic INT_EN_REG_ONE_WR,
  input wire logic [7:0] INT_EN_REG_ONE_WDATA,
  output logic WDT_RUN,
  output logic WDT_START,
  output logic POWER_SAVE_ALLOW
);
  ////////////////////////////////////////////////////////////////////
  // decode helpers

  // a single bit of the register write carries the request
  function automatic logic soft_start_req(
    input logic wr,
    input logic [7:0] wdata
  );
    logic req;
    req = wr && wdata[WDSC_SWSTART_BIT];
    return req;
  endfunction

  function automatic logic in_state(
    input wdsc_state_t cur,
    input wdsc_state_t want
  );
    logic hit;
    hit = (cur == want);
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin path

  logic pin_sync;

  wdsc_sync wdsc_sync_i (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .async_in(POWER_SAVE_ENABLE_PIN_N),
    .sync_out(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////
  // declarations

  wdsc_state_t state_q;
  wdsc_state_t state_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic settle_done;
  logic run_q;
  logic run_d;
  logic run_dly_q;
  logic start_q;
  logic start_d;
  logic allow_q;
  logic allow_d;
  logic sw_start;
  logic in_settle;
  logic in_run;

  ////////////////////////////////////////////////////////////////////
  // decode

  assign sw_start = soft_start_req(INT_EN_REG_ONE_WR, INT_EN_REG_ONE_WDATA);
  assign in_settle = in_state(state_q, WDSC_ST_SETTLE);
  assign in_run = in_state(state_q, WDSC_ST_RUN);
  assign settle_done = (settle_q == WDSC_STRAP_DELAY_C);

  ////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    state_d = state_q;
    case (state_q)
      WDSC_ST_RESET: begin
        state_d = WDSC_ST_SETTLE;
      end
      // wait for the synchroniser to hold the pin level seen at release
      WDSC_ST_SETTLE: begin
        if (settle_done) begin
          state_d = WDSC_ST_RUN;
        end
      end
      // final until the next hardware reset
      WDSC_ST_RUN: begin
        state_d = WDSC_ST_RUN;
      end
      default: begin
        state_d = WDSC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_q <= WDSC_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // settle counter

  // saturates, so it never wraps back into the strap window
  always_comb begin
    settle_d = settle_q;
    if (in_settle && !settle_done) begin
      settle_d = settle_q + 2'h1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      settle_q <= WDSC_SETTLE_RST;
    end else begin
      settle_q <= settle_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // run flag

  always_comb begin
    run_d = run_q;
    case (state_q)
      WDSC_ST_SETTLE: begin
        if (settle_done) begin
          run_d = pin_sync;
        end
      end
      WDSC_ST_RUN: begin
        if (sw_start) begin
          run_d = 1'h1;
        end
      end
      default: begin
        run_d = run_q;
      end
    endcase
  end

  // sticky: writing zero never stops it
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      run_q <= WDSC_RUN_RST;
    end else begin
      run_q <= run_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      run_dly_q <= WDSC_RUN_RST;
    end else begin
      run_dly_q <= run_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // start pulse

  // one cycle after the run flag rises
  always_comb begin
    start_d = run_q && !run_dly_q;
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      start_q <= WDSC_START_RST;
    end else begin
      start_q <= start_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power save gate

  // power save gate
  // held off while settling, the pin level is not trusted yet
  always_comb begin
    allow_d = in_run && !pin_sync;
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      allow_q <= WDSC_ALLOW_RST;
    end else begin
      allow_q <= allow_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign WDT_RUN = run_q;
  assign WDT_START = start_q;
  assign POWER_SAVE_ALLOW = allow_q;

endmodule // wdsc_top

// ==== hw/wdsc_pkg.sv ====
package wdsc_pkg;
  // pin synchroniser depth
  localparam int WDSC_SYNC_STAGES = 3;
  // reset value of the synchronised enable pin: pulled high when floating
  localparam logic WDSC_PIN_RST = 1'h1;
  // watchdog run flag after reset
  localparam logic WDSC_RUN_RST = 1'h0;
  // start pulse and power-save permission after reset
  localparam logic WDSC_START_RST = 1'h0;
  localparam logic WDSC_ALLOW_RST = 1'h0;
  // settle counter after reset
  localparam logic [1:0] WDSC_SETTLE_RST = 2'h0;
  // settle count before the strap is taken, on the fifth clock after reset release
  localparam int WDSC_STRAP_DELAY = 3;
  localparam logic [1:0] WDSC_STRAP_DELAY_C = 2'h3;
  // bit of the software start in the interrupt-enable register image
  localparam int WDSC_SWSTART_BIT = 6;

  typedef enum logic [1:0] {
    WDSC_ST_RESET,
    WDSC_ST_SETTLE,
    WDSC_ST_RUN
  } wdsc_state_t;
endpackage

// ==== hw/wdsc_sync.sv ====
`timescale 1ns/1ps
module wdsc_sync
  import wdsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic [WDSC_SYNC_STAGES-1:0] stage_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_q <= {WDSC_SYNC_STAGES{WDSC_PIN_RST}};
    end else begin
      stage_q <= {stage_q[WDSC_SYNC_STAGES-2:0], async_in};
    end
  end
  // change accepted once stages two and three agree
  logic filt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filt_q <= WDSC_PIN_RST;
    end else if (stage_q[1] == stage_q[2]) begin
      filt_q <= stage_q[2];
    end
  end
  assign sync_out = filt_q;
endmodule // wdsc_sync

// ==== dv/wdsc_board.sv ====
`timescale 1ns/1ps
module wdsc_board (
  input wire logic drive_en,
  input wire logic drive_val,
  output logic pin
);
  assign pin = drive_en ? drive_val : 1'h1;
endmodule // wdsc_board

// ==== dv/wdsc_properties.sv ====
`timescale 1ns/1ps
module wdsc_properties
  import wdsc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic POWER_SAVE_ENABLE_PIN_N,
  input wire logic INT_EN_REG_ONE_WR,
  input wire logic [7:0] INT_EN_REG_ONE_WDATA,
  input wire logic WDT_RUN,
  input wire logic WDT_START,
  input wire logic POWER_SAVE_ALLOW
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire logic sw = INT_EN_REG_ONE_WR && INT_EN_REG_ONE_WDATA[WDSC_SWSTART_BIT];
  wire logic p = POWER_SAVE_ENABLE_PIN_N;
  AST_STRAP_HI: assert property ($rose(RST_N) && p |-> ##[6:8] WDT_RUN)
    else $error("no auto start");
  AST_STRAP_LO: assert property ($rose(RST_N) && !p |-> !WDT_RUN [*8])
    else $error("started with low strap");
  AST_HOLD: assert property (WDT_RUN |=> WDT_RUN)
    else $error("watchdog stopped");
  AST_PULSE: assert property ($rose(WDT_RUN) |=> WDT_START ##1 !WDT_START)
    else $error("bad start pulse");
  AST_SW: assert property (sw && $past(RST_N, 8) |=> WDT_RUN)
    else $error("soft start lost");
  AST_NO_SW: assert property (!WDT_RUN && !sw && $past(RST_N, 8) |=> !WDT_RUN)
    else $error("unrequested start");
  AST_PS_HI: assert property (p [*6] |-> !POWER_SAVE_ALLOW)
    else $error("power save not blocked");
  AST_PS_LO: assert property (!p [*7] ##0 ($past(RST_N, 10) && $past(RST_N, 5))
    |-> POWER_SAVE_ALLOW)
    else $error("power save not allowed");
endmodule // wdsc_properties
bind wdsc_top wdsc_properties wdsc_properties_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .POWER_SAVE_ENABLE_PIN_N(POWER_SAVE_ENABLE_PIN_N), .INT_EN_REG_ONE_WR(INT_EN_REG_ONE_WR),
  .INT_EN_REG_ONE_WDATA(INT_EN_REG_ONE_WDATA), .WDT_RUN(WDT_RUN), .WDT_START(WDT_START),
  .POWER_SAVE_ALLOW(POWER_SAVE_ALLOW));

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst_n = 0, den = 0, dval = 0, wr = 0;
  logic [7:0] wd = 8'h00;
  logic pin, run, start, allow;
  int bad_count = 0, comparisons = 0, cyc = 0;
  always #50 clk = ~clk;
  wdsc_board wdsc_board_i (.drive_en(den), .drive_val(dval), .pin(pin));
  wdsc_top wdsc_top_i (.REF_CLK(clk), .RST_N(rst_n), .POWER_SAVE_ENABLE_PIN_N(pin),
    .INT_EN_REG_ONE_WR(wr), .INT_EN_REG_ONE_WDATA(wd), .WDT_RUN(run), .WDT_START(start),
    .POWER_SAVE_ALLOW(allow));
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // held 6 cycles: checker history depths rely on it
  task automatic do_reset(input logic en, input logic val);
    rst_n = 0;
    den = en;
    dval = val;
    w(6);
    rst_n = 1;
  endtask
  task automatic end_of_test;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic float_start;
    do_reset(1'h0, 1'h0);
    w(10);
    chk(run, 1'h1);
  endtask
  task automatic strap_low;
    do_reset(1'h1, 1'h0);
    w(10);
    chk(run, 1'h0);
    dval = 1;
    w(8);
    chk(run, 1'h0);
    chk(allow, 1'h0);
    dval = 0;
    w(8);
    chk(allow, 1'h1);
    wd = 8'hbf;
    wr = 1;
    w(1);
    chk(run, 1'h0);
    wd = 8'h40;
    w(1);
    wr = 0;
    chk(run, 1'h1);
    w(1);
    chk(start, 1'h1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 200) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    float_start();
    strap_low();
    end_of_test();
  end
endmodule // tb
